// [verilog/pus_defs.svh]
// constants for the power-up reset sequencer
`ifndef PUS_DEFS_SVH
`define PUS_DEFS_SVH
`define PUS_CLK_HZ 50000000
`define PUS_PH_OSC 1032
`define PUS_PH_FUSE 1160
`define PUS_PH_PUMP 688
`define PUS_PH_BANK 617
`define PUS_BOOT_ADDR 32'h0000_0000
`define PUS_SUP_GLITCH_NS 1000
`define PUS_SUP_GLITCH_MIN_NS 250
`define PUS_POR_FILT_NS 1000
`define PUS_POR_MIN_NS 475
`define PUS_POR_MAX_NS 2000
`define PUS_NUM_DOMAINS 5
`endif

// [verilog/pus_pkg.sv]
// types for the power-up reset sequencer
package pus_pkg;
	typedef enum logic [5:0] {
		PUS_WAIT = 6'h01,
		PUS_OSC = 6'h02,
		PUS_FUSE = 6'h04,
		PUS_PUMP = 6'h08,
		PUS_BANK = 6'h10,
		PUS_RUN = 6'h20
	} pus_state_t;
endpackage

// [verilog/pus_sequencer.sv]
// power-up reset sequencer with supply monitor and reset filter
`timescale 1ns/1ns
`include "pus_defs.svh"
module pus_sequencer #(
	parameter int SUP_FILT_NS = `PUS_SUP_GLITCH_NS,
	parameter int POR_FILT_NS = `PUS_POR_FILT_NS,
	parameter int OSC_CYC = `PUS_PH_OSC,
	parameter int FUSE_CYC = `PUS_PH_FUSE,
	parameter int PUMP_CYC = `PUS_PH_PUMP,
	parameter int BANK_CYC = `PUS_PH_BANK
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CORE_LOW,
	input wire logic CORE_HIGH,
	input wire logic IO_LOW,
	input wire logic LOW_POWER_MODE,
	input wire logic POWER_ON_RESET_N,
	input wire logic [3:0] DOMAIN_ON_REQ,
	input wire logic DOMAIN_CFG_STB,
	output logic CORE_POWER_GOOD,
	output logic IO_POWER_GOOD,
	output logic ISOLATE,
	output logic PINS_HIGH_Z,
	output logic INT_POR,
	output logic CPU_RESET,
	output logic [31:0] BOOT_ADDR,
	output logic [2:0] PHASE,
	output logic [`PUS_NUM_DOMAINS-1:0] DOMAIN_ON
);
	localparam int NS_PER_CYC = 1000000000 / `PUS_CLK_HZ;
	// longest ignored time rounds down
	localparam int SUP_CYC = (SUP_FILT_NS / NS_PER_CYC) < 1 ? 1 :
		SUP_FILT_NS / NS_PER_CYC;
	localparam int POR_CYC = (POR_FILT_NS / NS_PER_CYC) < 1 ? 1 :
		POR_FILT_NS / NS_PER_CYC;
	localparam int CW = 12;

	if (POR_FILT_NS < `PUS_POR_MIN_NS ||
		POR_FILT_NS > `PUS_POR_MAX_NS) begin : g_bad_por
		$error("power-on reset filter outside allowed window");
	end
	if (SUP_FILT_NS < `PUS_SUP_GLITCH_MIN_NS ||
		SUP_FILT_NS > `PUS_SUP_GLITCH_NS) begin : g_bad_sup
		$error("supply glitch filter outside allowed window");
	end
	if (SUP_CYC >= (1 << CW) || POR_CYC >= (1 << CW) ||
		OSC_CYC >= (1 << CW) || FUSE_CYC >= (1 << CW) ||
		PUMP_CYC >= (1 << CW) || BANK_CYC >= (1 << CW) ||
		OSC_CYC < 1 || PUMP_CYC < 1 || BANK_CYC < 1 ||
		FUSE_CYC < 1) begin : g_bad_cnt
		$error("count parameter out of range");
	end

	default clocking pus_cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	typedef struct packed {
		pus_pkg::pus_state_t st;
		logic [CW-1:0] cnt;
		logic [CW-1:0] sup_cnt;
		logic sup_bad;
		logic [CW-1:0] por_cnt;
		logic por_act;
		logic [3:0] dom;
		logic cfg_done;
	} pus_regs_t;

	pus_regs_t q, d;
	logic core_raw, io_raw, mon_bad;

	// core out of range bypasses the clock so pins float immediately
	assign core_raw = ~LOW_POWER_MODE & (CORE_LOW | CORE_HIGH);
	assign io_raw = ~LOW_POWER_MODE & IO_LOW;
	assign PINS_HIGH_Z = core_raw | q.sup_bad;
	assign mon_bad = q.sup_bad;
	assign CORE_POWER_GOOD = ~mon_bad;
	assign IO_POWER_GOOD = ~mon_bad;
	assign ISOLATE = mon_bad;
	assign INT_POR = mon_bad | q.por_act;
	assign CPU_RESET = (q.st != pus_pkg::PUS_RUN);
	assign BOOT_ADDR = `PUS_BOOT_ADDR;
	assign DOMAIN_ON = {q.dom, 1'b1};

	always_comb begin
		case (q.st)
			pus_pkg::PUS_OSC: PHASE = 3'h1;
			pus_pkg::PUS_FUSE: PHASE = 3'h2;
			pus_pkg::PUS_PUMP: PHASE = 3'h3;
			pus_pkg::PUS_BANK: PHASE = 3'h4;
			pus_pkg::PUS_RUN: PHASE = 3'h5;
			default: PHASE = 3'h0;
		endcase
	end

	always_comb begin
		d = q;
		// supply glitch filter: bad level must persist SUP_CYC cycles
		if (core_raw | io_raw) begin
			if (q.sup_cnt >= CW'(SUP_CYC))
				d.sup_bad = 1'b1;
			else
				d.sup_cnt = q.sup_cnt + 1'b1;
		end else begin
			d.sup_cnt = '0;
			d.sup_bad = 1'b0;
		end
		// reset pin filter: low level must persist POR_CYC cycles
		if (!POWER_ON_RESET_N) begin
			if (q.por_cnt >= CW'(POR_CYC))
				d.por_act = 1'b1;
			else
				d.por_cnt = q.por_cnt + 1'b1;
		end else begin
			d.por_cnt = '0;
			d.por_act = 1'b0;
		end
		d.cnt = q.cnt + 1'b1;
		case (q.st)
			pus_pkg::PUS_WAIT: begin
				d.cnt = '0;
				d.st = pus_pkg::PUS_OSC;
			end
			pus_pkg::PUS_OSC: begin
				if (q.cnt == CW'(OSC_CYC - 1)) begin
					d.cnt = '0;
					d.st = pus_pkg::PUS_FUSE;
				end
			end
			pus_pkg::PUS_FUSE: begin
				if (q.cnt == CW'(FUSE_CYC - 1)) begin
					d.cnt = '0;
					d.st = pus_pkg::PUS_PUMP;
				end
			end
			pus_pkg::PUS_PUMP: begin
				if (q.cnt == CW'(PUMP_CYC - 1)) begin
					d.cnt = '0;
					d.st = pus_pkg::PUS_BANK;
				end
			end
			pus_pkg::PUS_BANK: begin
				if (q.cnt == CW'(BANK_CYC - 1)) begin
					d.cnt = '0;
					d.st = pus_pkg::PUS_RUN;
				end
			end
			default: begin
				d.cnt = '0;
				// one-time domain choice while software initializes
				if (DOMAIN_CFG_STB && !q.cfg_done) begin
					d.dom = DOMAIN_ON_REQ;
					d.cfg_done = 1'b1;
				end
			end
		endcase
		// any reset cause abandons the sequence
		if (INT_POR) begin
			d.st = pus_pkg::PUS_WAIT;
			d.cnt = '0;
			d.dom = '1;
			d.cfg_done = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			q <= '{st: pus_pkg::PUS_WAIT, cnt: '0, sup_cnt: '0,
				sup_bad: 1'b0, por_cnt: '0, por_act: 1'b1,
				dom: '1, cfg_done: 1'b0};
		end else begin
			q <= d;
		end
	end

	int unsigned run_len;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST)
			run_len <= 0;
		else if (CPU_RESET && !INT_POR && q.st != pus_pkg::PUS_WAIT)
			run_len <= run_len + 1;
		else
			run_len <= 0;
	end

	// consecutive bad-supply and low-pin samples, kept apart from the
	// filter counters so the checks do not lean on them
	int unsigned bad_run, low_run;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			bad_run <= 0;
			low_run <= 0;
		end else begin
			bad_run <= (core_raw | io_raw) ? bad_run + 1 : 0;
			low_run <= !POWER_ON_RESET_N ? low_run + 1 : 0;
		end
	end

	a_release_total: assert property (
		$fell(CPU_RESET) |->
		$past(run_len) == OSC_CYC + FUSE_CYC + PUMP_CYC + BANK_CYC - 1)
		else $error("cpu reset released at wrong cycle");
	a_phase_order: assert property (
		(PHASE == 3'h2 && $changed(PHASE)) |-> $past(PHASE) == 3'h1)
		else $error("fuse phase not entered from oscillator phase");
	a_pump_after: assert property (
		(PHASE == 3'h4 && $changed(PHASE)) |-> $past(PHASE) == 3'h3)
		else $error("bank phase not entered from pump phase");
	a_boot_zero: assert property (
		!CPU_RESET |-> BOOT_ADDR == 32'h0000_0000)
		else $error("boot address not zero");
	a_start_gate: assert property (
		(PHASE == 3'h1 && $changed(PHASE)) |-> !$past(INT_POR))
		else $error("sequence started under reset");
	a_pg_both: assert property (
		CORE_POWER_GOOD == IO_POWER_GOOD && (ISOLATE == !CORE_POWER_GOOD))
		else $error("power good and isolation disagree");
	a_pg_low: assert property (
		bad_run > SUP_CYC |-> !CORE_POWER_GOOD && !IO_POWER_GOOD)
		else $error("power good high on lasting supply fault");
	a_sup_ignore: assert property (
		$rose(q.sup_bad) |-> $past(bad_run) * NS_PER_CYC >= SUP_FILT_NS)
		else $error("supply glitch not ignored");
	a_bad_filtered: assert property (
		(io_raw && bad_run >= SUP_CYC) |=> INT_POR)
		else $error("low io supply did not assert reset");
	a_core_hz: assert property (
		(!LOW_POWER_MODE && (CORE_LOW || CORE_HIGH)) |-> PINS_HIGH_Z)
		else $error("pins not tristated on core fault");
	a_lp_quiet: assert property (
		LOW_POWER_MODE [*2] |-> !ISOLATE)
		else $error("monitor active in low power mode");
	a_por_short: assert property (
		$rose(q.por_act) |-> $past(low_run) * NS_PER_CYC >= `PUS_POR_MIN_NS)
		else $error("short reset pulse taken");
	a_por_long: assert property (
		low_run * NS_PER_CYC > `PUS_POR_MAX_NS |-> INT_POR)
		else $error("long reset pulse not taken");
	a_restart: assert property (
		INT_POR |=> CPU_RESET && PHASE == 3'h0)
		else $error("sequence not abandoned on reset");
	a_aon_on: assert property (
		DOMAIN_ON[0] && $countones(DOMAIN_ON) <= `PUS_NUM_DOMAINS)
		else $error("always-on domain off");
	a_dom_once: assert property (
		(q.cfg_done && !INT_POR) |=> $stable(q.dom))
		else $error("domain changed twice");
endmodule // pus_sequencer

// [verification/pus_supervisor.sv]
// external supervisor model driving the power-on reset pin
`timescale 1ns/1ns
module pus_supervisor (
	input wire logic supply_bad,
	input wire logic hold_req,
	output logic por_n
);
	// actively driven, so the pin never floats to a stale level
	assign por_n = !(supply_bad || hold_req);
endmodule // pus_supervisor

// [verification/testbench.sv]
// self-checking bench for the power-up reset sequencer
`timescale 1ns/1ns
module testbench;
	typedef struct {logic [2:0] ph; int len;} pus_row_t;
	logic clk, rst, core_low, core_high, io_low, lpm, hold, stb, por_n;
	logic cpg, iopg, iso, hz, ipor, cpu_rst;
	logic [3:0] req;
	logic [31:0] boot;
	logic [2:0] phase;
	logic [4:0] dom;
	int failures, cmp_count, n;
	// shortened phases, all distinct so a swapped order shows; fuse and
	// pump together outlast the reset filter so a mid-sequence reset can land
	pus_row_t rows[4] = '{'{3'h1, 40}, '{3'h2, 50}, '{3'h3, 60},
		'{3'h4, 70}};
	pus_sequencer #(.OSC_CYC(40), .FUSE_CYC(50), .PUMP_CYC(60),
		.BANK_CYC(70))
	dut_u (.SYS_CLK(clk), .RST(rst), .CORE_LOW(core_low), .CORE_HIGH(core_high),
		.IO_LOW(io_low), .LOW_POWER_MODE(lpm), .POWER_ON_RESET_N(por_n),
		.DOMAIN_ON_REQ(req), .DOMAIN_CFG_STB(stb), .CORE_POWER_GOOD(cpg),
		.IO_POWER_GOOD(iopg), .ISOLATE(iso), .PINS_HIGH_Z(hz), .INT_POR(ipor),
		.CPU_RESET(cpu_rst), .BOOT_ADDR(boot), .PHASE(phase), .DOMAIN_ON(dom));
	pus_supervisor sup_u (.supply_bad(core_low | core_high | io_low),
		.hold_req(hold), .por_n(por_n));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask
	// bounded wait; phase is read before the edge's updates land
	task automatic wait_ph(input logic [2:0] p);
		n = 0;
		while (phase !== p && n < 400) begin
			@(posedge clk);
			n++;
		end
		chk(phase, p);
	endtask
	task automatic strobe(input logic [3:0] v);
		req <= v;
		stb <= 1'b1;
		tick(1);
		stb <= 1'b0;
		tick(2);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d errors %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		tick(5000);
		failures++;
		report_and_stop();
	end
	initial begin
		{rst, hold, core_low, core_high, io_low, lpm, stb} = 7'h60;
		req = 4'h0;
		tick(16);
		chk({cpu_rst, ipor, phase, dom}, {2'h3, 3'h0, 5'h1F});
		chk(boot, 32'h0000_0000);
		rst <= 1'b0;
		tick(120);
		chk(phase, 3'h0);
		hold <= 1'b0;
		wait_ph(3'h1);
		foreach (rows[i]) begin
			n = 0;
			while (phase === rows[i].ph && n < 200) begin
				@(posedge clk);
				n++;
			end
			chk(n, rows[i].len);
		end
		chk({phase, cpu_rst}, {3'h5, 1'b0});
		strobe(4'h5);
		chk(dom, 5'h0B);
		strobe(4'hA);
		chk(dom, 5'h0B);
		// short dip also pulses the pin under the filter time
		io_low <= 1'b1;
		tick(20);
		io_low <= 1'b0;
		tick(2);
		chk({iopg, cpg, ipor}, 3'h6);
		io_low <= 1'b1;
		tick(60);
		chk({iopg, cpg, iso, ipor, cpu_rst}, 5'h07);
		io_low <= 1'b0;
		wait_ph(3'h5);
		core_high <= 1'b1;
		#1 chk(hz, 1'b1);
		tick(60);
		chk(ipor, 1'b1);
		core_high <= 1'b0;
		lpm <= 1'b1;
		io_low <= 1'b1;
		tick(60);
		chk({iopg, iso}, 2'h2);
		{io_low, lpm} <= 2'h0;
		wait_ph(3'h2);
		hold <= 1'b1;
		tick(53);
		chk({ipor, phase, cpu_rst}, 5'h11);
		hold <= 1'b0;
		wait_ph(3'h1);
		wait_ph(3'h5);
		report_and_stop();
	end
endmodule // testbench
